// file: logic/rrdf_pkg.sv
// Constants, codes and the state record of the radio receive decoder.
// Assumes a single 250 MHz clock domain and an AXI4-Lite master.
package rrdf_pkg;
	// ************************************************************
	// Register map (byte addresses)
	// ************************************************************
	localparam logic [7:0] RRDF_CTRL_OFS = 8'h00;
	localparam logic [7:0] RRDF_BAUD_OFS = 8'h04;
	localparam logic [7:0] RRDF_RXDATA_OFS = 8'h08;
	localparam logic [7:0] RRDF_FIFO_OFS = 8'h0c;
	localparam logic [7:0] RRDF_IRQ_ST_OFS = 8'h10;
	localparam logic [7:0] RRDF_IRQ_CLR_OFS = 8'h14;
	localparam logic [7:0] RRDF_IRQ_EN_OFS = 8'h18;
	// ************************************************************
	// Control fields
	// ************************************************************
	localparam int RRDF_RX_EN_BIT = 0;
	localparam int RRDF_TX_EN_BIT = 1;
	localparam int RRDF_DEC_EN_BIT = 2;
	localparam int RRDF_CODE_LSB = 3;
	localparam int RRDF_START_LSB = 6;
	localparam int RRDF_IRQSRC_LSB = 8;
	localparam int RRDF_BITCLK_BIT = 11;
	localparam int RRDF_EXTCLK_BIT = 12;
	localparam int RRDF_COARSE_LSB = 0;
	localparam int RRDF_FINE_LSB = 2;
	localparam int RRDF_IRQ_RX_BIT = 0;
	localparam int RRDF_IRQ_OVF_BIT = 1;
	localparam logic [12:0] RRDF_CTRL_RST = 13'h0000;
	localparam logic [5:0] RRDF_BAUD_RST = 6'h00;
	localparam logic [1:0] RRDF_IRQ_RST = 2'h0;
	// ************************************************************
	// Codes and timing
	// ************************************************************
	localparam logic [2:0] RRDF_CODE_NRZ_MARK = 3'h1;
	localparam logic [2:0] RRDF_CODE_MANCH_LEVEL = 3'h3;
	localparam logic [1:0] RRDF_START_NONE = 2'h0;
	localparam logic [1:0] RRDF_START_VIOL = 2'h1;
	localparam logic [1:0] RRDF_START_PATTERN = 2'h2;
	localparam logic [2:0] RRDF_IRQSRC_START = 3'h1;
	localparam logic [2:0] RRDF_IRQSRC_FULL = 3'h4;
	localparam logic [3:0] RRDF_SAMPLE_PHASE = 4'h7;
	localparam logic [2:0] RRDF_FIFO_DEPTH = 3'h4;
	localparam logic [1:0] RRDF_RESP_OKAY = 2'h0;
	localparam logic [1:0] RRDF_RESP_SLVERR = 2'h2;
	// ************************************************************
	// Types
	// ************************************************************
	typedef enum logic {RX_HUNT = 1'b0, RX_RUN = 1'b1} rrdf_rx_t;
	typedef struct packed {
		logic ext_clk;
		logic bit_clk;
		logic pattern;
		logic data;
	} rrdf_pins_t;
	typedef struct packed {
		rrdf_pins_t s1, s2, s3;
		logic ext_half;
		logic [10:0] osc;
		logic [3:0] sub;
		logic half, first, prev;
		rrdf_rx_t rx;
		logic [2:0] bits;
		logic [7:0] shreg;
		logic [3:0][7:0] mem;
		logic [1:0] wp, rp;
		logic [2:0] cnt;
		logic [12:0] ctrl;
		logic [5:0] baud;
		logic [1:0] ist, ien;
		logic aw_got;
		logic [7:0] awaddr;
		logic w_got;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} rrdf_state_t;
endpackage

// file: logic/rrdf_rx.sv
// Radio receive path: baud timing, line decoding, start detection,
// four byte FIFO, interrupt status, AXI4-Lite register slave.
// Assumes radio pins are asynchronous and the bus is on aclk.
//
// Register access over AXI4-Lite and the address map are this design's own decisions.
`timescale 1ns/1ps
// Notes on behaviour
// - Receive only with rx enabled, tx disabled
// - Divide clock by 16 times (fine+1) times 4 to the power coarse
// - External clock source runs logic at half
// - Bit clock select 0 ignores external bit clock
// - Code 001 decodes NRZ Mark
// - Start mode 10 uses pattern-detect pin
// - Irq source 001 fires on start detect
// - Irq source 100 fires on FIFO full
// - Four byte FIFO, reads pop oldest
// - Byte into full FIFO sets overflow, lost
// - Start detection flushes the FIFO
// - Manchester takes two symbols per bit
// - Start mode 01 uses protocol violation
// - Code 011 decodes Manchester Level
module rrdf_rx
	import rrdf_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire rrdf_pins_t radio_pins,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic rx_irq
);
	rrdf_state_t q, d;
	logic rx_on, ext_rise, bclk_rise, pat_rise, base_tick, osc_tick;
	logic sym_ev, line, bit_ev, bit_val, viol, start_ev, byte_done;
	logic push, pop, full_now, ar_hs, wr_go, manch;
	logic [4:0] fine1;
	logic [10:0] prod;
	logic [2:0] code, irq_src;
	logic [1:0] smode, ev;
	logic [31:0] wmask, rd_word;

	// ************************************************************
	// Bus handshakes
	// ************************************************************
	assign s_axi_awready = !q.aw_got && !q.bvalid;
	assign s_axi_wready = !q.w_got && !q.bvalid;
	assign s_axi_arready = !q.rvalid;
	assign s_axi_bvalid = q.bvalid;
	assign s_axi_bresp = q.bresp;
	assign s_axi_rvalid = q.rvalid;
	assign s_axi_rdata = q.rdata;
	assign s_axi_rresp = q.rresp;
	assign rx_irq = |(q.ist & q.ien);

	always_comb
	begin
		d = q;
		// ************************************************************
		// Pin synchronisers and edges
		// ************************************************************
		d.s1 = radio_pins;
		d.s2 = q.s1;
		d.s3 = q.s2;
		ext_rise = q.s2.ext_clk & ~q.s3.ext_clk;
		bclk_rise = q.s2.bit_clk & ~q.s3.bit_clk;
		pat_rise = q.s2.pattern & ~q.s3.pattern;
		line = q.s2.data;
		rx_on = q.ctrl[RRDF_RX_EN_BIT] & ~q.ctrl[RRDF_TX_EN_BIT];
		code = q.ctrl[RRDF_CODE_LSB +: 3];
		smode = q.ctrl[RRDF_START_LSB +: 2];
		irq_src = q.ctrl[RRDF_IRQSRC_LSB +: 3];
		manch = q.ctrl[RRDF_DEC_EN_BIT] && code == RRDF_CODE_MANCH_LEVEL;
		// ************************************************************
		// Baud generation
		// ************************************************************
		// Every other external edge: the external clock is halved
		d.ext_half = q.ext_half ^ ext_rise;
		base_tick = q.ctrl[RRDF_EXTCLK_BIT] ? (ext_rise & q.ext_half) : 1'b1;
		fine1 = {1'b0, q.baud[RRDF_FINE_LSB +: 4]} + 5'h01;
		prod = 11'({6'h00, fine1} << {q.baud[RRDF_COARSE_LSB +: 2], 1'b0});
		osc_tick = base_tick && q.osc == prod - 11'h001;
		if (base_tick)
			d.osc = osc_tick ? 11'h000 : q.osc + 11'h001;
		if (osc_tick)
			d.sub = q.sub + 4'h1;
		// Realign the 16 phase sampler on each line edge
		if (q.s2.data != q.s3.data && !q.ctrl[RRDF_BITCLK_BIT])
			d.sub = 4'h0;
		sym_ev = q.ctrl[RRDF_BITCLK_BIT] ? bclk_rise
			: (osc_tick && q.sub == RRDF_SAMPLE_PHASE);
		// ************************************************************
		// Line decoding
		// ************************************************************
		bit_ev = 1'b0;
		bit_val = line;
		viol = 1'b0;
		if (sym_ev && rx_on)
		begin
			d.prev = line;
			if (manch)
			begin
				// Symbol rate is twice the bit rate here
				d.half = ~q.half;
				if (!q.half)
					d.first = line;
				else if (line == q.first)
					viol = 1'b1;
				else
				begin
					bit_ev = 1'b1;
					bit_val = q.first;
				end
			end
			else
			begin
				bit_ev = 1'b1;
				if (q.ctrl[RRDF_DEC_EN_BIT] && code == RRDF_CODE_NRZ_MARK)
					bit_val = line ^ q.prev;
			end
		end
		// ************************************************************
		// Start detection and byte assembly
		// ************************************************************
		case (smode)
			RRDF_START_VIOL: start_ev = rx_on && viol;
			RRDF_START_PATTERN: start_ev = rx_on && pat_rise;
			default: start_ev = 1'b0;
		endcase
		byte_done = 1'b0;
		case (q.rx)
			RX_HUNT:
			begin
				d.bits = 3'h0;
				if (rx_on && (start_ev || smode == RRDF_START_NONE))
					d.rx = RX_RUN;
			end
			RX_RUN:
			begin
				if (bit_ev)
				begin
					d.shreg = {q.shreg[6:0], bit_val};
					d.bits = q.bits + 3'h1;
					byte_done = q.bits == 3'h7;
				end
				if (start_ev)
				begin
					d.bits = 3'h0;
					d.half = 1'b0;
					byte_done = 1'b0;
				end
				if (!rx_on)
					d.rx = RX_HUNT;
			end
			default: d.rx = RX_HUNT;
		endcase
		// ************************************************************
		// Register slave
		// ************************************************************
		if (s_axi_awvalid && s_axi_awready)
		begin
			d.aw_got = 1'b1;
			d.awaddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready)
		begin
			d.w_got = 1'b1;
			d.wdata = s_axi_wdata;
			d.wstrb = s_axi_wstrb;
		end
		if (q.bvalid && s_axi_bready)
			d.bvalid = 1'b0;
		wr_go = q.aw_got && q.w_got && !q.bvalid;
		wmask = {{8{q.wstrb[3]}}, {8{q.wstrb[2]}}, {8{q.wstrb[1]}}, {8{q.wstrb[0]}}};
		ev = 2'h0;
		if (wr_go)
		begin
			d.aw_got = 1'b0;
			d.w_got = 1'b0;
			d.bvalid = 1'b1;
			d.bresp = RRDF_RESP_OKAY;
			case (q.awaddr)
				RRDF_CTRL_OFS: d.ctrl = 13'((q.wdata & wmask) | ({19'h0, q.ctrl} & ~wmask));
				RRDF_BAUD_OFS: d.baud = 6'((q.wdata & wmask) | ({26'h0, q.baud} & ~wmask));
				RRDF_IRQ_CLR_OFS: d.ist = q.ist & ~(q.wdata[1:0] & wmask[1:0]);
				RRDF_IRQ_EN_OFS: d.ien = 2'((q.wdata & wmask) | ({30'h0, q.ien} & ~wmask));
				default: d.bresp = RRDF_RESP_SLVERR;
			endcase
		end
		ar_hs = s_axi_arvalid && s_axi_arready;
		if (q.rvalid && s_axi_rready)
			d.rvalid = 1'b0;
		pop = ar_hs && s_axi_araddr == RRDF_RXDATA_OFS && q.cnt != 3'h0;
		case (s_axi_araddr)
			RRDF_CTRL_OFS: rd_word = {19'h0, q.ctrl};
			RRDF_BAUD_OFS: rd_word = {26'h0, q.baud};
			RRDF_RXDATA_OFS: rd_word = pop ? {24'h0, q.mem[q.rp]} : 32'h0;
			RRDF_FIFO_OFS: rd_word = {27'h0, q.rx, q.cnt, q.cnt == 3'h0};
			RRDF_IRQ_ST_OFS: rd_word = {30'h0, q.ist};
			RRDF_IRQ_EN_OFS: rd_word = {30'h0, q.ien};
			default: rd_word = 32'h0;
		endcase
		if (ar_hs)
		begin
			d.rvalid = 1'b1;
			d.rdata = rd_word;
			d.rresp = (s_axi_araddr == RRDF_IRQ_CLR_OFS || s_axi_araddr > RRDF_IRQ_EN_OFS)
				? RRDF_RESP_SLVERR : RRDF_RESP_OKAY;
		end
		// ************************************************************
		// Receive FIFO
		// ************************************************************
		full_now = q.cnt == RRDF_FIFO_DEPTH;
		push = byte_done && !full_now;
		if (byte_done && full_now)
			ev[RRDF_IRQ_OVF_BIT] = 1'b1;
		if (push)
		begin
			d.mem[q.wp] = q.shreg[6:0] == 7'h00 ? {7'h00, bit_val} : {q.shreg[6:0], bit_val};
			d.wp = q.wp + 2'h1;
		end
		if (pop)
			d.rp = q.rp + 2'h1;
		d.cnt = q.cnt + {2'h0, push} - {2'h0, pop};
		// A pop while full does not free the slot in time; the push is still refused;
		// keeping the two paths apart trades one byte for simplicity.
		if (start_ev)
		begin
			d.wp = 2'h0;
			d.rp = 2'h0;
			d.cnt = 3'h0;
		end
		if (start_ev && irq_src == RRDF_IRQSRC_START)
			ev[RRDF_IRQ_RX_BIT] = 1'b1;
		if (push && q.cnt == RRDF_FIFO_DEPTH - 3'h1 && irq_src == RRDF_IRQSRC_FULL && !pop)
			ev[RRDF_IRQ_RX_BIT] = 1'b1;
		// Set wins over a clear in the same cycle
		d.ist = d.ist | ev;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			q <= '0;
			q.ctrl <= RRDF_CTRL_RST;
			q.baud <= RRDF_BAUD_RST;
			q.ist <= RRDF_IRQ_RST;
			q.ien <= RRDF_IRQ_RST;
		end
		else
			q <= d;
	end

	// ************************************************************
	// Checks
	// ************************************************************
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	sequence full_push_s;
		byte_done && full_now && !start_ev;
	endsequence
	sequence start_s;
		start_ev;
	endsequence

	fifo_depth_a: assert property (q.cnt <= RRDF_FIFO_DEPTH)
		else $error("fifo count above depth");
	pop_order_a: assert property (pop |=> q.rdata[7:0] == $past(q.mem[q.rp]))
		else $error("read did not return oldest byte");
	ovf_set_a: assert property (full_push_s |=> q.ist[RRDF_IRQ_OVF_BIT])
		else $error("overflow flag not set");
	full_keep_a: assert property (full_push_s ##0 !pop |=> q.mem == $past(q.mem)
		&& q.cnt == RRDF_FIFO_DEPTH)
		else $error("failed write changed fifo");
	start_flush_a: assert property (start_s |=> q.cnt == 3'h0 && q.rp == q.wp)
		else $error("start did not flush fifo");
	start_irq_a: assert property (start_s ##0 irq_src == RRDF_IRQSRC_START
		|=> q.ist[RRDF_IRQ_RX_BIT] ##1 q.ist[RRDF_IRQ_RX_BIT] || $past(wr_go))
		else $error("start interrupt missing");
	full_irq_a: assert property (irq_src == RRDF_IRQSRC_FULL && push && !pop && !start_ev
		&& q.cnt == 3'h3 |=> q.ist[RRDF_IRQ_RX_BIT] && q.cnt == 3'h4)
		else $error("full interrupt missing");
	irq_gate_a: assert property (q.ien == 2'h0 |-> !rx_irq)
		else $error("interrupt passed while disabled");
	rx_gate_a: assert property (!rx_on |=> q.rx == RX_HUNT ##1 !byte_done)
		else $error("receiver ran while disabled");
	ovf_sticky_a: assert property (q.ist[RRDF_IRQ_OVF_BIT] && !wr_go
		|=> q.ist[RRDF_IRQ_OVF_BIT])
		else $error("overflow flag dropped");
	baud_div_a: assert property (!q.ctrl[RRDF_EXTCLK_BIT] && q.osc != prod - 11'h001
		&& $stable(q.baud) |=> q.osc == $past(q.osc) + 11'h001)
		else $error("baud prescaler skipped");
	manch_pair_a: assert property (manch && sym_ev && rx_on && !q.half
		|-> !bit_ev && !viol)
		else $error("manchester bit on first half");
endmodule // rrdf_rx

// file: testbench/rrdf_radio_model.sv
// Transceiver model: demodulated NRZ Mark data and pattern-detect pulses.
// Assumes 16 clocks per symbol (baud fine 0, coarse 0, internal clock).
`timescale 1ns/1ps
module rrdf_radio_model
	import rrdf_pkg::*;
(
	input wire logic aclk,
	output rrdf_pins_t pins
);
	// ************************************************************
	// Line driving
	// ************************************************************
	initial pins = '0;
	// Noise on the bit clock shows that the block ignores it
	always @(posedge aclk) pins.bit_clk <= 1'($urandom_range(1, 0));
	// Mode pins are taken as held at receive; the block has no such pins
	// Data line stays driven between frames, as a demodulator output does
	task automatic send(input logic start, input logic [7:0] q[$]);
		if (start)
		begin
			pins.data <= ~pins.data;
			repeat (10) @(posedge aclk);
			pins.pattern <= 1'b1;
			repeat (6) @(posedge aclk);
			pins.pattern <= 1'b0;
		end
		foreach (q[k])
			for (int i = 7; i >= 0; i--)
			begin
				if (q[k][i])
					pins.data <= ~pins.data;
				repeat (16) @(posedge aclk);
			end
	endtask
endmodule // rrdf_radio_model

// file: testbench/radio_rx_decoder_fifo_test.sv
// Self-checking bench of the radio receive block over AXI4-Lite.
// Assumes the transceiver model and a single 250 MHz clock.
`timescale 1ns/1ps
module radio_rx_decoder_fifo_test;
	import rrdf_pkg::*;
	logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready, rx_irq;
	logic [7:0] awaddr, araddr;
	logic [31:0] wdata, rdata, rd_v;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp, rd_r, br;
	logic [7:0] q[$];
	rrdf_pins_t pins;
	int fail_count, compares;
	rrdf_rx dut_u (.aclk(aclk), .aresetn(aresetn), .radio_pins(pins),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready), .rx_irq(rx_irq));
	rrdf_radio_model radio_u (.aclk(aclk), .pins(pins));
	// ************************************************************
	// Helpers
	// ************************************************************
	initial
	begin
		aclk = 1'b0;
		forever #2 aclk = ~aclk;
	end
	function automatic logic [31:0] ctrl(input logic [2:0] src, input logic tx);
		return 32'(1) | 32'(tx) << RRDF_TX_EN_BIT | 32'(1) << RRDF_DEC_EN_BIT
			| 32'(RRDF_CODE_NRZ_MARK) << RRDF_CODE_LSB
			| 32'(RRDF_START_PATTERN) << RRDF_START_LSB | 32'(src) << RRDF_IRQSRC_LSB;
	endfunction
	function automatic logic [31:0] stat(input int n);
		return 32'(n) << 1 | 32'(n == 0);
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp)
		begin
			fail_count++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic print_verdict();
		if (fail_count == 0 && compares > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic give_up();
		fail_count++;
		print_verdict();
	endtask
	// Address and data offered together; each released once taken
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic b;
		int n;
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		n = 0;
		do
		begin
			// Everything is sampled at the rising edge, before the design updates
			@(posedge aclk);
			if (awvalid && awready)
				awvalid <= 1'b0;
			if (wvalid && wready)
				wvalid <= 1'b0;
			b = bvalid && bready;
			br = bresp;
			n++;
			if (n > 200)
				give_up();
		end while (!b);
		bready <= 1'b0;
		@(posedge aclk);
	endtask
	task automatic rd(input logic [7:0] a);
		logic r;
		int n;
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		n = 0;
		do
		begin
			@(posedge aclk);
			if (arvalid && arready)
				arvalid <= 1'b0;
			r = rvalid && rready;
			rd_v = rdata;
			rd_r = rresp;
			n++;
			if (n > 200)
				give_up();
		end while (!r);
		rready <= 1'b0;
		@(posedge aclk);
	endtask
	initial
	begin
		repeat (100000) @(posedge aclk);
		give_up();
	end
	// ************************************************************
	// Scenarios
	// ************************************************************
	initial
	begin
		{aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
		{awaddr, araddr, wdata} = '0;
		wstrb = 4'hf;
		fail_count = 0;
		compares = 0;
		void'($urandom(10));
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rd(RRDF_CTRL_OFS);
		chk(rd_v, 32'h0);
		rd(RRDF_FIFO_OFS);
		chk(rd_v & 32'hf, stat(0));
		rd(8'h40);
		chk(32'(rd_r), 32'(RRDF_RESP_SLVERR));
		wr(8'h44, 32'h1);
		chk(32'(br), 32'(RRDF_RESP_SLVERR));
		wr(RRDF_IRQ_EN_OFS, 32'h3);
		wr(RRDF_BAUD_OFS, 32'h0);
		wr(RRDF_CTRL_OFS, ctrl(RRDF_IRQSRC_START, 1'b0));
		q = {};
		radio_u.send(1'b1, q);
		repeat (2) @(posedge aclk);
		chk(32'(rx_irq), 32'h1);
		rd(RRDF_IRQ_ST_OFS);
		chk(rd_v, 32'h1);
		wr(RRDF_IRQ_CLR_OFS, 32'h1);
		chk(32'(rx_irq), 32'h0);
		// Source changed while reception runs
		wr(RRDF_CTRL_OFS, ctrl(RRDF_IRQSRC_FULL, 1'b0));
		repeat (4) q.push_back(8'($urandom));
		radio_u.send(1'b1, q);
		chk(32'(rx_irq), 32'h1);
		foreach (q[k])
		begin
			rd(RRDF_RXDATA_OFS);
			chk(rd_v, {24'h0, q[k]});
		end
		rd(RRDF_FIFO_OFS);
		chk(rd_v & 32'hf, stat(0));
		wr(RRDF_IRQ_CLR_OFS, 32'h1);
		q = {8'hff, 8'h00, 8'($urandom), 8'($urandom), 8'($urandom)};
		radio_u.send(1'b1, q);
		rd(RRDF_IRQ_ST_OFS);
		chk(rd_v, 32'h3);
		wr(RRDF_IRQ_EN_OFS, 32'h0);
		chk(32'(rx_irq), 32'h0);
		wr(RRDF_IRQ_EN_OFS, 32'h3);
		for (int k = 0; k < 4; k++)
		begin
			rd(RRDF_RXDATA_OFS);
			chk(rd_v, {24'h0, q[k]});
		end
		rd(RRDF_IRQ_ST_OFS);
		chk(rd_v & 32'h2, 32'h2);
		wr(RRDF_IRQ_CLR_OFS, 32'h3);
		q = {8'($urandom), 8'($urandom)};
		radio_u.send(1'b1, q);
		q = {8'($urandom)};
		radio_u.send(1'b1, q);
		rd(RRDF_FIFO_OFS);
		chk(rd_v & 32'hf, stat(1));
		rd(RRDF_RXDATA_OFS);
		chk(rd_v, {24'h0, q[0]});
		// Transmitter enabled too: nothing may be received
		wr(RRDF_CTRL_OFS, ctrl(RRDF_IRQSRC_FULL, 1'b1));
		q = {8'hff};
		radio_u.send(1'b1, q);
		rd(RRDF_FIFO_OFS);
		chk(rd_v & 32'hf, stat(0));
		print_verdict();
	end
endmodule // radio_rx_decoder_fifo_test
